// File: design/psv_defines.svh
// psv_defines.svh: constants for the program store, vector and table-read block.
// assumes inclusion by bare name from design files; definitions only.
`ifndef PSV_DEFINES_SVH
`define PSV_DEFINES_SVH

`define PSV_PC_W        13
`define PSV_WORD_W      16
`define PSV_DEPTH       8192
`define PSV_RESET_PC    13'h0000
`define PSV_VEC_USB     13'h0004
`define PSV_VEC_TMR0    13'h0008
`define PSV_VEC_TMR1    13'h000C
`define PSV_VEC_SER     13'h0010
`define PSV_VEC_EXT     13'h0014
`define PSV_LAST_PAGE   5'h1F
`define PSV_STACK_DEPTH 8
`define PSV_SP_W        4
`define PSV_NUM_IRQ     5
`define PSV_BYTE_W      8
`define PSV_PAGE_LSB    8
`define PSV_HP_MSB      4

// register indices on the plain register port
`define PSV_ADDR_W      3
`define PSV_REG_TBLP    3'h0
`define PSV_REG_TABLE_POINTER_HIGH    3'h1
`define PSV_REG_TABLE_READ_HIGH_BYTE    3'h2
`define PSV_REG_PC_LO   3'h3
`define PSV_REG_PC_HI   3'h4
`define PSV_REG_PEND    3'h5
`define PSV_REG_SP      3'h6

`endif

// File: design/psv_pkg.sv
// psv_pkg.sv: types shared by the program store block.
// assumes nothing beyond a SystemVerilog compiler.
package psv_pkg;
	typedef enum logic [1:0] {
		PSV_OP_NONE,
		PSV_OP_TBL_CUR,
		PSV_OP_TBL_LAST
	} psv_op_e;

	typedef enum {
		PSV_ST_IDLE,
		PSV_ST_TBL_FETCH
	} psv_state_e;
endpackage : psv_pkg

// File: design/psv_program_store.sv
// psv_program_store.sv: program store, program counter, vectors and table reads.
// assumes a core that issues one command per instruction cycle of clk, and a
// program loader writing the store through the load port before release.
//
// Function
// - 8K x 16 program store, read by the program counter and by table pointers.
// - reset loads the program counter with address zero.
// - enabled usb request with stack free vectors to 004H.
// - enabled timer 0 overflow with stack free vectors to 008H.
// - enabled timer 1 overflow with stack free vectors to 00CH.
// - enabled serial unit request with stack free vectors to 010H.
// - enabled external edge with stack free vectors to 014H.
// - pointer-high off: current-page read uses pc bits 12..8 and low pointer.
// - pointer-high on: current-page read takes bits 12..8 from high pointer bits 4..0.
// - last-page read forces bits 12..8 to ones, low pointer below.
// - low byte goes to named data location, upper bits to high-byte register.
// - upper word bits sit low in high-byte register, unused bits read zero.
// - high-byte register is read-only; writes leave it unchanged.
// - both table pointers are readable and writable by software.
// - with pointer-high disabled, its value never reaches a table address.
// - each table read takes two cycles, word fetched in the second.
// - on acknowledge the current pc is pushed before the vector loads.
// - full stack latches request, defers acknowledge until a return frees a level.
`timescale 1ns/100ps
`include "psv_defines.svh"

module psv_program_store #(
	parameter int PC_W   = `PSV_PC_W,
	parameter int WORD_W = `PSV_WORD_W,
	parameter int DEPTH  = `PSV_DEPTH
) (
	input  wire logic                     clk,
	input  wire logic                     rstn,
	// store loading port
	input  wire logic                     load_we,
	input  wire logic [PC_W-1:0]          load_addr,
	input  wire logic [WORD_W-1:0]        load_data,
	// configuration option
	input  wire logic                     table_pointer_high_en,
	// core commands, one cycle pulses
	input  wire logic                     pc_step,
	input  wire logic                     pc_jump,
	input  wire logic [PC_W-1:0]          pc_target,
	input  wire logic                     pc_call,
	input  wire logic                     pc_return,
	input  wire logic                     table_read,
	input  wire logic                     table_read_last,
	input  wire logic [7:0]               table_dest_in,
	// interrupt sources and enables
	input  wire logic [`PSV_NUM_IRQ-1:0]  irq_event,
	input  wire logic [`PSV_NUM_IRQ-1:0]  irq_enable,
	// register port
	input  wire logic [`PSV_ADDR_W-1:0]   reg_addr,
	input  wire logic [7:0]               reg_wdata,
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	output logic      [7:0]               reg_rdata,
	// fetch and table results
	output logic      [PC_W-1:0]          pc,
	output logic      [WORD_W-1:0]        instr,
	output logic                          irq_ack,
	output logic      [PC_W-1:0]          irq_vector,
	output logic                          table_busy,
	output logic                          table_wr,
	output logic      [7:0]               table_dest,
	output logic      [7:0]               table_low_byte,
	output logic                          stack_full
);

	// upper word bits that land in the high-byte register
	localparam int HI_W   = WORD_W - `PSV_BYTE_W;
	localparam int SLOT_W = `PSV_SP_W - 1;

	////////////////////////////////////////////////////////////////////////
	// timing seen by the core, one line per interface
	//   reset: pc, stack pointer, pending flags and pointers all clear
	//   register read: strobe at edge n, data stands only in cycle n+1
	//   register write: lands at the strobe edge, no wait states
	//   table read: command edge n, busy in n+1, result pulse in n+2
	//   table read: commands during the busy cycle are dropped
	//   table read: address is frozen at the command edge
	//   interrupt: event edge n, pending in n+1, vector loaded at n+2
	//   interrupt: ack pulse comes in the same cycle as the vector load
	//   interrupt: a call or table command holds the acknowledge off
	//   interrupt: a step, jump or return in the ack cycle is lost
	//   the high-byte register is overwritten by every table read, so an
	//   interrupt routine that reads tables clobbers the main routine's copy
	//   the stack has no readback path; a full stack defers interrupts

	////////////////////////////////////////////////////////////////////////
	// storage
	logic [WORD_W-1:0]        mem [0:DEPTH-1];

	// return stack
	logic [PC_W-1:0]          stack_r [0:`PSV_STACK_DEPTH-1];
	logic [`PSV_SP_W-1:0]     sp_r;

	// table pointers and result
	logic [7:0]               table_pointer_low_r;
	logic [7:0]               table_pointer_high_r;
	logic [7:0]               table_read_high_byte_r;
	psv_pkg::psv_state_e      state_r;
	logic [PC_W-1:0]          tbl_addr_r;
	logic [7:0]               dest_r;

	// interrupts
	logic [`PSV_NUM_IRQ-1:0]  pend_r;

	logic [PC_W-1:0]          tbl_addr_nxt;
	logic [`PSV_NUM_IRQ-1:0]  ack_onehot;
	logic [PC_W-1:0]          vec_nxt;
	logic                     ack_nxt;
	logic                     full_now;
	logic                     sw_wr_tbl;
	logic                     tbl_idle;
	logic                     cmd_holds_ack;
	logic [SLOT_W-1:0]        push_slot;
	logic [SLOT_W-1:0]        pop_slot;
	logic [7:0]               rd_mux;

	assign full_now      = (sp_r == `PSV_SP_W'(`PSV_STACK_DEPTH));
	assign tbl_idle      = (state_r == psv_pkg::PSV_ST_IDLE);
	assign cmd_holds_ack = table_read || table_read_last || pc_call;
	// slot index wraps: an overflowing call reuses slot zero
	assign push_slot     = sp_r[SLOT_W-1:0];
	assign pop_slot      = push_slot - SLOT_W'(1);

	always_ff @(posedge clk) begin
		if (load_we) begin
			mem[load_addr] <= load_data;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// table address forming
	always_comb begin
		if (table_read_last) begin
			tbl_addr_nxt = {`PSV_LAST_PAGE, table_pointer_low_r};
		end else if (table_pointer_high_en) begin
			tbl_addr_nxt = {table_pointer_high_r[`PSV_HP_MSB:0], table_pointer_low_r};
		end else begin
			tbl_addr_nxt = {pc[PC_W-1:`PSV_PAGE_LSB], table_pointer_low_r};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt pending flags and lowest-vector pick
	always_comb begin
		ack_onehot = '0;
		for (int i = `PSV_NUM_IRQ-1; i >= 0; i--) begin
			if (pend_r[i] && irq_enable[i]) begin
				ack_onehot = '0;
				ack_onehot[i] = 1'b1;
			end
		end
		// no vector while a table read is mid-flight or the stack is full
		ack_nxt = (|ack_onehot) && !full_now && tbl_idle && !cmd_holds_ack;
		case (1'b1)
			ack_onehot[0]: vec_nxt = `PSV_VEC_USB;
			ack_onehot[1]: vec_nxt = `PSV_VEC_TMR0;
			ack_onehot[2]: vec_nxt = `PSV_VEC_TMR1;
			ack_onehot[3]: vec_nxt = `PSV_VEC_SER;
			ack_onehot[4]: vec_nxt = `PSV_VEC_EXT;
			default:       vec_nxt = `PSV_RESET_PC;
		endcase
	end

	generate
		for (genvar g = 0; g < `PSV_NUM_IRQ; g++) begin : g_pend
			always_ff @(posedge clk) begin
				if (!rstn) begin
					pend_r[g] <= 1'b0;
				// set beats clear: an event in the ack cycle stays pending
				end else if (irq_event[g]) begin
					pend_r[g] <= 1'b1;
				end else if (ack_nxt && ack_onehot[g]) begin
					pend_r[g] <= 1'b0;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// program counter and stack
	always_ff @(posedge clk) begin
		if (!rstn) begin
			pc   <= `PSV_RESET_PC;
			sp_r <= '0;
		end else if (ack_nxt) begin
			stack_r[push_slot] <= pc;
			sp_r <= sp_r + `PSV_SP_W'(1);
			pc   <= vec_nxt;
		end else if (pc_call) begin
			// overflowing call overwrites a level; software must avoid it
			stack_r[push_slot] <= pc + PC_W'(1);
			if (!full_now) begin
				sp_r <= sp_r + `PSV_SP_W'(1);
			end
			pc <= pc_target;
		end else if (pc_return && sp_r != '0) begin
			// a return on an empty stack is ignored
			sp_r <= sp_r - `PSV_SP_W'(1);
			pc   <= stack_r[pop_slot];
		end else if (pc_jump) begin
			pc <= pc_target;
		end else if (pc_step) begin
			pc <= pc + PC_W'(1);
		end
	end

	// acknowledge pulse and the vector it carried
	always_ff @(posedge clk) begin
		if (!rstn) begin
			irq_ack    <= 1'b0;
			irq_vector <= `PSV_RESET_PC;
		end else begin
			irq_ack    <= ack_nxt;
			irq_vector <= ack_nxt ? vec_nxt : irq_vector;
		end
	end

	// lags the pointer by a cycle, like the acknowledge
	always_ff @(posedge clk) begin
		if (!rstn) begin
			stack_full <= 1'b0;
		end else begin
			stack_full <= full_now;
		end
	end

	// instr lags pc by one cycle
	always_ff @(posedge clk) begin
		instr <= mem[pc];
	end

	////////////////////////////////////////////////////////////////////////
	// table read sequencer
	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_r    <= psv_pkg::PSV_ST_IDLE;
			table_busy <= 1'b0;
			tbl_addr_r <= '0;
			dest_r     <= '0;
		end else begin
			case (state_r)
				psv_pkg::PSV_ST_IDLE: begin
					if (table_read || table_read_last) begin
						state_r    <= psv_pkg::PSV_ST_TBL_FETCH;
						table_busy <= 1'b1;
						tbl_addr_r <= tbl_addr_nxt;
						dest_r     <= table_dest_in;
					end
				end
				psv_pkg::PSV_ST_TBL_FETCH: begin
					state_r    <= psv_pkg::PSV_ST_IDLE;
					table_busy <= 1'b0;
				end
				default: begin
					state_r    <= psv_pkg::PSV_ST_IDLE;
					table_busy <= 1'b0;
				end
			endcase
		end
	end

	// one-cycle result pulse
	always_ff @(posedge clk) begin
		if (!rstn) begin
			table_wr <= 1'b0;
		end else begin
			table_wr <= (state_r == psv_pkg::PSV_ST_TBL_FETCH);
		end
	end

	// results hold until the next table read overwrites them
	always_ff @(posedge clk) begin
		if (!rstn) begin
			table_dest             <= '0;
			table_low_byte         <= '0;
			table_read_high_byte_r <= '0;
		end else if (state_r == psv_pkg::PSV_ST_TBL_FETCH) begin
			table_dest             <= dest_r;
			table_low_byte         <= mem[tbl_addr_r][`PSV_BYTE_W-1:0];
			// zero-extended, so unused upper bits always read zero
			table_read_high_byte_r <= 8'(mem[tbl_addr_r][WORD_W-1:WORD_W-HI_W]);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register port
	// the high-byte register has no write path at all
	assign sw_wr_tbl = reg_wr;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			table_pointer_low_r  <= '0;
			table_pointer_high_r <= '0;
		end else if (sw_wr_tbl) begin
			case (reg_addr)
				`PSV_REG_TBLP: table_pointer_low_r  <= reg_wdata;
				`PSV_REG_TABLE_POINTER_HIGH: table_pointer_high_r <= reg_wdata;
				default: ;
			endcase
		end
	end

	// unmapped indices read zero
	always_comb begin
		case (reg_addr)
			`PSV_REG_TBLP:  rd_mux = table_pointer_low_r;
			`PSV_REG_TABLE_POINTER_HIGH:  rd_mux = table_pointer_high_r;
			`PSV_REG_TABLE_READ_HIGH_BYTE:  rd_mux = table_read_high_byte_r;
			`PSV_REG_PC_LO: rd_mux = pc[`PSV_PAGE_LSB-1:0];
			`PSV_REG_PC_HI: rd_mux = 8'(pc[PC_W-1:`PSV_PAGE_LSB]);
			`PSV_REG_PEND:  rd_mux = 8'(pend_r);
			`PSV_REG_SP:    rd_mux = 8'(sp_r);
			default:        rd_mux = '0;
		endcase
	end

	// read data stands for the one cycle after the strobe only
	always_ff @(posedge clk) begin
		if (!rstn) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			reg_rdata <= rd_mux;
		end else begin
			reg_rdata <= '0;
		end
	end

endmodule : psv_program_store

// File: testbench/psv_properties.sv
// psv_properties.sv: concurrent checks on the program store block ports.
// assumes binding onto psv_program_store, one clock, rstn synchronous.
`timescale 1ns/100ps
module psv_properties #(
	parameter int PC_W = 13
) (
	input wire logic            clk,
	input wire logic            rstn,
	input wire logic            table_read,
	input wire logic            table_read_last,
	input wire logic [7:0]      table_dest_in,
	input wire logic            reg_rd,
	input wire logic [7:0]      reg_rdata,
	input wire logic [PC_W-1:0] pc,
	input wire logic            irq_ack,
	input wire logic [PC_W-1:0] irq_vector,
	input wire logic            table_busy,
	input wire logic            table_wr,
	input wire logic [7:0]      table_dest,
	input wire logic            stack_full
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	////////////////////////////////////////
	sequence s_fetch;
		table_busy ##1 table_wr;
	endsequence
	AST_RESET_PC: assert property ($rose(rstn) |-> pc == '0)
		else $error("pc not zero after reset");
	AST_TBL_FETCH: assert property ((table_read || table_read_last) && !table_busy |=> s_fetch)
		else $error("table read not two cycles");
	AST_BUSY_ONE: assert property (table_busy |=> !table_busy)
		else $error("busy held too long");
	AST_WR_DEST: assert property (table_wr |-> !$past(table_wr) && table_dest == $past(table_dest_in, 2))
		else $error("table destination wrong");
	AST_ACK_VEC: assert property (irq_ack |-> pc == irq_vector)
		else $error("pc not at vector on acknowledge");
	AST_VEC_SET: assert property (irq_ack |-> irq_vector inside {13'h0004, 13'h0008, 13'h000C, 13'h0010, 13'h0014})
		else $error("vector outside table");
	// two full cycles so a one-cycle lag on the flag cannot trip it
	AST_FULL_HOLD: assert property (stack_full ##1 stack_full |-> !irq_ack)
		else $error("acknowledge with full stack");
	AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data without read");
endmodule : psv_properties
bind psv_program_store psv_properties #(.PC_W(PC_W)) u_props (.clk, .rstn, .table_read, .table_read_last,
	.table_dest_in, .reg_rd, .reg_rdata, .pc, .irq_ack, .irq_vector, .table_busy, .table_wr, .table_dest,
	.stack_full);

// File: testbench/psv_core_model.sv
// psv_core_model.sv: behavioural execution core issuing pc and table commands.
// assumes one caller process; commands are one cycle, one idle cycle apart.
`timescale 1ns/100ps
module psv_core_model (
	input wire logic clk,
	output logic        pc_step,
	output logic        pc_jump,
	output logic        pc_call,
	output logic        pc_return,
	output logic        table_read,
	output logic        table_read_last,
	output logic [12:0] pc_target,
	output logic [7:0]  table_dest_in
);
	initial begin
		{pc_step, pc_jump, pc_call, pc_return, table_read, table_read_last} = '0;
		pc_target = '0;
		table_dest_in = '0;
	end
	// k: 0 step, 1 jump, 2 call, 3 return, 4 current page, 5 last page
	task automatic issue(input int k, input logic [12:0] t, input logic [7:0] d);
		@(posedge clk);
		{pc_step, pc_jump, pc_call, pc_return, table_read, table_read_last} <= 6'h20 >> k;
		pc_target <= t;
		table_dest_in <= d;
		@(posedge clk);
		{pc_step, pc_jump, pc_call, pc_return, table_read, table_read_last} <= '0;
		// stale qualifiers inverted so a late sample never matches
		pc_target <= ~t;
		table_dest_in <= ~d;
	endtask : issue
endmodule : psv_core_model

// File: testbench/psv_program_store_tb_top.sv
// psv_program_store_tb_top.sv: self-checking bench with a store model.
// assumes core model and checker compiled first.
`timescale 1ns/100ps
`include "psv_defines.svh"
module psv_program_store_tb_top;
	logic clk = 0, rstn = 0, load_we = 0, en = 0, reg_wr = 0, reg_rd = 0;
	logic [12:0] load_addr = '0, pc_target, pc, irq_vector, pm, ta;
	logic [15:0] load_data = '0, instr;
	logic [4:0] irq_event = '0, irq_enable = '0;
	logic [2:0] reg_addr = '0;
	logic [7:0] reg_wdata = '0, reg_rdata, table_dest_in, table_dest, table_low_byte, lo, hi, hb;
	logic pc_step, pc_jump, pc_call, pc_return, table_read, table_read_last, irq_ack, table_busy, table_wr, stack_full;
	logic [15:0] m [8192];
	logic [12:0] vec [5] = '{`PSV_VEC_USB, `PSV_VEC_TMR0, `PSV_VEC_TMR1, `PSV_VEC_SER, `PSV_VEC_EXT};
	int n_mismatch = 0, compares = 0;
	always #20 clk = ~clk;
	psv_core_model core (.clk, .pc_step, .pc_jump, .pc_call, .pc_return, .table_read, .table_read_last,
		.pc_target, .table_dest_in);
	psv_program_store dut (.clk, .rstn, .load_we, .load_addr, .load_data, .table_pointer_high_en(en), .pc_step,
		.pc_jump, .pc_target, .pc_call, .pc_return, .table_read, .table_read_last, .table_dest_in, .irq_event,
		.irq_enable, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pc, .instr, .irq_ack, .irq_vector,
		.table_busy, .table_wr, .table_dest, .table_low_byte, .stack_full);
	////////////////////////////////////////
	task automatic chk(input logic [23:0] g, input logic [23:0] e);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask : rd
	task automatic rst();
		@(posedge clk);
		rstn <= 1'b0;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		#1 pm = '0;
	endtask : rst
	task automatic fire(input logic [4:0] b);
		@(posedge clk);
		irq_event <= b;
		@(posedge clk);
		irq_event <= '0;
	endtask : fire
	task automatic wack(input logic [12:0] v);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			#1 n++;
		end while (irq_ack !== 1'b1 && n < 20);
		chk({irq_ack, irq_vector}, {1'b1, v});
	endtask : wack
	task automatic tbl(input int k);
		logic [7:0] d;
		d = 8'($urandom);
		core.issue(k, '0, d);
		ta = (k == 5) ? {`PSV_LAST_PAGE, lo} : en ? {hi[4:0], lo} : {pm[12:8], lo};
		@(posedge clk);
		#1 chk({table_wr, table_dest, table_low_byte}, {1'b1, d, m[ta][7:0]});
		hb = m[ta][15:8];
		rd(`PSV_REG_TABLE_READ_HIGH_BYTE, hb);
	endtask : tbl
	task automatic test_done();
		if (n_mismatch == 0 && compares > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : test_done
	////////////////////////////////////////
	initial begin
		#(40 * 30000);
		n_mismatch++;
		test_done();
	end
	initial begin
		void'($urandom(32'hf7d5_bbc2));
		for (int a = 0; a < 8192; a++) begin
			@(posedge clk);
			m[a] = 16'($urandom);
			load_we <= 1'b1;
			load_addr <= 13'(a);
			load_data <= m[a];
		end
		@(posedge clk);
		load_we <= 1'b0;
		rst();
		chk(pc, 13'h0000);
		rd(`PSV_REG_TABLE_READ_HIGH_BYTE, 8'h00);
		lo = 8'($urandom);
		hi = 8'($urandom);
		wr(`PSV_REG_TBLP, lo);
		wr(`PSV_REG_TABLE_POINTER_HIGH, hi);
		rd(`PSV_REG_TBLP, lo);
		rd(`PSV_REG_TABLE_POINTER_HIGH, hi);
		rd(3'h7, 8'h00);
		// interrupts stay masked while table reads run
		tbl(5);
		wr(`PSV_REG_TABLE_READ_HIGH_BYTE, ~hb);
		rd(`PSV_REG_TABLE_READ_HIGH_BYTE, hb);
		pm = 13'($urandom);
		core.issue(1, pm, '0);
		@(posedge clk);
		#1 chk(instr, m[pm]);
		tbl(4);
		en <= 1'b1;
		tbl(4);
		en <= 1'b0;
		irq_enable <= 5'h1F;
		for (int i = 0; i < 5; i++) begin
			fire(5'h01 << i);
			wack(vec[i]);
			core.issue(3, '0, '0);
			#1 chk(pc, pm);
		end
		fire(5'h0A);
		wack(`PSV_VEC_TMR0);
		wack(`PSV_VEC_SER);
		core.issue(3, '0, '0);
		#1 chk(pc, `PSV_VEC_TMR0);
		core.issue(3, '0, '0);
		for (int i = 0; i < 8; i++) core.issue(2, 13'(i), '0);
		@(posedge clk);
		#1 chk(stack_full, 1'b1);
		fire(5'h10);
		repeat (6) begin
			@(posedge clk);
			#1 chk(irq_ack, 1'b0);
		end
		core.issue(3, '0, '0);
		wack(`PSV_VEC_EXT);
		rst();
		chk({stack_full, pc}, 14'h0000);
		test_done();
	end
endmodule : psv_program_store_tb_top
